//--- hdl/fsbdp_tx_end.sv
// fsbdp_tx_end: data driving agent, user words in, quad-pumped bus out
// assumes a free running link clock; one link cycle is one sub-phase
`default_nettype none

// ------------------------------------------------------------------
// word fifo, single clock
// ------------------------------------------------------------------
module fsbdp_fifo #(
  parameter int WIDTH = fsbdp_pkg::DATA_W,
  parameter int DEPTH = fsbdp_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // fill side
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  // drain side
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  import fsbdp_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("fifo depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic [AW:0] cnt_d;
  logic rdy_q;
  logic push;
  logic pop;

  assign push = i_valid & rdy_q;
  assign pop = o_valid & i_ready;
  assign o_ready = rdy_q;
  assign o_valid = cnt_q != '0;
  assign o_data = mem_q[rd_q];

  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem_q[wr_q] <= i_data;
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      rdy_q <= 1'b0;
    end else begin
      wr_q <= wr_q + AW'(push);
      rd_q <= rd_q + AW'(pop);
      cnt_q <= cnt_d;
      // registered so the fill side sees a clean flop
      rdy_q <= cnt_d != FULL;
    end
  end

endmodule // fsbdp_fifo

// ------------------------------------------------------------------
// driving end
// ------------------------------------------------------------------
module fsbdp_tx_end #(
  parameter fsbdp_pkg::fsbdp_freq_t FREQ_SEL = fsbdp_pkg::FREQ_SEL_RST,
  parameter int DEPTH = fsbdp_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // user word stream
  input wire logic i_word_valid,
  input wire fsbdp_pkg::fsbdp_word_t i_word,
  output logic o_word_ready,
  // status
  output logic o_freq_mismatch,
  // link
  fsbdp_link_if.tx link
);
  import fsbdp_pkg::*;

  typedef enum logic {FILL_COLLECT, FILL_WAIT} fsbdp_fill_t;
  typedef enum logic {LNK_IDLE, LNK_BURST} fsbdp_lnk_t;

  // ----------------------------------------------------------------
  // word fifo and line assembly (mclk)
  // ----------------------------------------------------------------
  fsbdp_word_t f_data;
  logic f_valid;
  logic f_ready;
  fsbdp_fill_t fill_q;
  fsbdp_sub_t cnt_q;
  logic [N_SUB-1:0][DATA_W-1:0] line_q;
  logic req_q;
  // link side toggle, declared here because the ack synchroniser reads it
  logic ack_tgl_q;
  logic [2:0] ack_s_q;
  logic ack_lvl_q;
  logic [2:0][1:0] fm_s_q;
  logic mism_q;

  fsbdp_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_valid(i_word_valid),
    .o_ready(o_word_ready),
    .i_data(i_word),
    .o_valid(f_valid),
    .i_ready(f_ready),
    .o_data(f_data)
  );

  // drain stalls while a line waits, so back-pressure reaches the user
  assign f_ready = fill_q == FILL_COLLECT;

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      fill_q <= FILL_COLLECT;
      cnt_q <= SUB_FIRST;
      req_q <= 1'b0;
    end else begin
      unique case (fill_q)
        FILL_COLLECT: begin
          if (f_valid) begin
            cnt_q <= cnt_q + SUB_STEP;
            if (cnt_q == SUB_LAST) begin
              req_q <= ~req_q;
              fill_q <= FILL_WAIT;
            end
          end
        end
        FILL_WAIT: begin
          if (ack_lvl_q == req_q) begin
            fill_q <= FILL_COLLECT;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (f_valid && f_ready) begin
      line_q[cnt_q] <= f_data;
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      ack_s_q <= '0;
      ack_lvl_q <= 1'b0;
    end else begin
      ack_s_q <= {ack_s_q[1:0], ack_tgl_q};
      if (ack_s_q[1] == ack_s_q[2]) begin
        ack_lvl_q <= ack_s_q[2];
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      fm_s_q <= '0;
      mism_q <= 1'b0;
    end else begin
      fm_s_q <= {fm_s_q[1:0], link.bus_freq_select};
      if (fm_s_q[1] == fm_s_q[2]) begin
        mism_q <= fm_s_q[2] != FREQ_SEL;
      end
    end
  end

  assign o_freq_mismatch = mism_q;

  // ----------------------------------------------------------------
  // link side (link clock)
  // ----------------------------------------------------------------
  logic [2:0] req_s_q;
  logic req_lvl_q;
  logic [2:0][1:0] lf_s_q;
  logic freq_ok_q;
  fsbdp_sub_t sub_q;
  fsbdp_lnk_t lnk_q;
  logic [N_SUB-1:0][DATA_W-1:0] shift_q;
  fsbdp_sub_t nsub;
  logic go;
  logic load;
  fsbdp_word_t src;
  fsbdp_word_t pins;
  logic [N_GRP-1:0] inv;

  always_ff @(posedge link.clk_link or negedge i_nrst) begin
    if (!i_nrst) begin
      req_s_q <= '0;
      req_lvl_q <= 1'b0;
      lf_s_q <= '0;
      freq_ok_q <= 1'b0;
    end else begin
      req_s_q <= {req_s_q[1:0], req_q};
      if (req_s_q[1] == req_s_q[2]) begin
        req_lvl_q <= req_s_q[2];
      end
      lf_s_q <= {lf_s_q[1:0], link.bus_freq_select};
      if (lf_s_q[1] == lf_s_q[2]) begin
        freq_ok_q <= lf_s_q[2] == FREQ_SEL;
      end
    end
  end

  // a common clock starts at sub-phase 0; bursts begin only there
  always_comb begin
    nsub = sub_q + SUB_STEP;
    load = (sub_q == SUB_LAST) && (req_lvl_q != ack_tgl_q) && freq_ok_q;
    go = (sub_q == SUB_LAST) ? load : (lnk_q == LNK_BURST);
    // line_q is held still until the ack toggle comes back
    src = load ? line_q[SUB_FIRST] : shift_q[nsub];
    for (int k = 0; k < N_GRP; k++) begin
      inv[k] = fsbdp_want_invert(src[k*GRP_W +: GRP_W]);
      pins[k*GRP_W +: GRP_W] =
        fsbdp_flip(src[k*GRP_W +: GRP_W], inv[k]);
    end
  end

  always_ff @(posedge link.clk_link or negedge i_nrst) begin
    if (!i_nrst) begin
      sub_q <= SUB_FIRST;
      lnk_q <= LNK_IDLE;
      ack_tgl_q <= 1'b0;
    end else begin
      sub_q <= nsub;
      if (sub_q == SUB_LAST) begin
        lnk_q <= load ? LNK_BURST : LNK_IDLE;
        if (load) begin
          ack_tgl_q <= ~ack_tgl_q;
        end
      end
    end
  end

  always_ff @(posedge link.clk_link) begin
    if (load) begin
      shift_q <= line_q;
    end
  end

  always_ff @(posedge link.clk_link or negedge i_nrst) begin
    if (!i_nrst) begin
      link.drv_oe <= 1'b0;
      link.valid_drv_n <= PIN_IDLE;
      link.data_drv_n <= '1;
      link.invert_drv_n <= '1;
      link.strobe_pos_drv_n <= '1;
      link.strobe_neg_drv_n <= '1;
    end else begin
      link.drv_oe <= go;
      link.valid_drv_n <= ~go;
      link.data_drv_n <= go ? pins : '1;
      link.invert_drv_n <= go ? ~inv : '1;
      // pos falls in sub-phases 0 and 2, neg in 1 and 3
      link.strobe_pos_drv_n <= go ? {N_GRP{nsub[0]}} : '1;
      link.strobe_neg_drv_n <= go ? {N_GRP{~nsub[0]}} : '1;
    end
  end

endmodule // fsbdp_tx_end

`default_nettype wire

//--- hdl/fsbdp_pkg.sv
// fsbdp_pkg: shared widths, codes and helpers for the data path ends
// assumes both ends and the link interface import it
`default_nettype none

package fsbdp_pkg;

  // ----------------------------------------------------------------
  // widths and counts
  // ----------------------------------------------------------------
  localparam int DATA_W = 64;
  localparam int GRP_W = 16;
  localparam int N_GRP = 4;
  localparam int N_SUB = 4;
  localparam int LINE_W = DATA_W * N_SUB;
  localparam int FIFO_DEPTH = 8;

  // ----------------------------------------------------------------
  // codes and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] FREQ_SEL_RST = 2'h0;
  localparam logic [1:0] SUB_FIRST = 2'h0;
  localparam logic [1:0] SUB_LAST = 2'h3;
  localparam logic [1:0] SUB_STEP = 2'h1;
  localparam logic PIN_IDLE = 1'h1;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef logic [DATA_W-1:0] fsbdp_word_t;
  typedef logic [LINE_W-1:0] fsbdp_line_t;
  typedef logic [1:0] fsbdp_sub_t;
  typedef logic [1:0] fsbdp_freq_t;
  typedef logic [GRP_W-1:0] fsbdp_grp_t;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // a logical one is an electrically low pin on this active-low bus
  function automatic logic fsbdp_want_invert(input fsbdp_grp_t g);
    int unsigned ones;
    ones = 0;
    for (int i = 0; i < GRP_W; i++) begin
      ones += int'(g[i]);
    end
    return ones > GRP_W / 2;
  endfunction

  // pin level <-> logical value; same map both ways
  function automatic fsbdp_grp_t fsbdp_flip(input fsbdp_grp_t g,
                                            input logic inv);
    return inv ? g : ~g;
  endfunction

endpackage : fsbdp_pkg

`default_nettype wire

//--- hdl/fsbdp_link_if.sv
// fsbdp_link_if: the shared data bus wires between the two ends
// assumes the bench supplies the link clock; undriven pins pull high
`default_nettype none

interface fsbdp_link_if (
  input wire logic clk_link
);
  import fsbdp_pkg::*;

  // ----------------------------------------------------------------
  // driver side levels and enable
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] data_drv_n;
  logic [N_GRP-1:0] invert_drv_n;
  logic [N_GRP-1:0] strobe_pos_drv_n;
  logic [N_GRP-1:0] strobe_neg_drv_n;
  logic valid_drv_n;
  logic drv_oe;

  // ----------------------------------------------------------------
  // resolved wire levels
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] data_n;
  logic [N_GRP-1:0] group_invert_flag_n;
  logic [N_GRP-1:0] data_strobe_pos_n;
  logic [N_GRP-1:0] data_strobe_neg_n;
  logic data_valid_n;
  fsbdp_freq_t bus_freq_select;

  // termination pulls every released pin to the inactive level
  assign data_n = drv_oe ? data_drv_n : '1;
  assign group_invert_flag_n = drv_oe ? invert_drv_n : '1;
  assign data_strobe_pos_n = drv_oe ? strobe_pos_drv_n : '1;
  assign data_strobe_neg_n = drv_oe ? strobe_neg_drv_n : '1;
  assign data_valid_n = drv_oe ? valid_drv_n : 1'b1;

  modport tx (
    input clk_link,
    input bus_freq_select,
    output data_drv_n,
    output invert_drv_n,
    output strobe_pos_drv_n,
    output strobe_neg_drv_n,
    output valid_drv_n,
    output drv_oe
  );

  modport rx (
    input clk_link,
    input data_n,
    input group_invert_flag_n,
    input data_strobe_pos_n,
    input data_strobe_neg_n,
    input data_valid_n,
    output bus_freq_select
  );

endinterface : fsbdp_link_if

`default_nettype wire

//--- hdl/fsbdp_rx_end.sv
// fsbdp_rx_end: receiving agent, strobe capture and line delivery
// assumes the driver keeps the strobe timing of the tx end
`default_nettype none

module fsbdp_rx_end #(
  parameter fsbdp_pkg::fsbdp_freq_t FREQ_SEL = fsbdp_pkg::FREQ_SEL_RST
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // link
  fsbdp_link_if.rx link,
  // user line out
  output fsbdp_pkg::fsbdp_line_t o_line,
  output logic o_line_valid
);
  import fsbdp_pkg::*;

  // ----------------------------------------------------------------
  // frequency select
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      link.bus_freq_select <= FREQ_SEL;
    end else begin
      link.bus_freq_select <= FREQ_SEL;
    end
  end

  // ----------------------------------------------------------------
  // strobe capture (link clock)
  // ----------------------------------------------------------------
  logic [N_GRP-1:0] pos_prev_q;
  logic [N_GRP-1:0] neg_prev_q;
  logic [N_GRP-1:0] fall;
  fsbdp_sub_t slot_q [N_GRP];
  logic [N_SUB-1:0][DATA_W-1:0] cap_q;
  fsbdp_line_t hold_q;
  logic done_tgl_q;
  fsbdp_word_t word;
  logic done;

  always_comb begin
    for (int k = 0; k < N_GRP; k++) begin
      // both strobes of a pair latch; they alternate sub-phases
      fall[k] = (pos_prev_q[k] & ~link.data_strobe_pos_n[k]) |
                (neg_prev_q[k] & ~link.data_strobe_neg_n[k]);
      word[k*GRP_W +: GRP_W] = fsbdp_flip(link.data_n[k*GRP_W +: GRP_W],
        ~link.group_invert_flag_n[k]);
    end
    done = fall[0] && !link.data_valid_n && slot_q[0] == SUB_LAST;
  end

  always_ff @(posedge link.clk_link or negedge i_nrst) begin
    if (!i_nrst) begin
      pos_prev_q <= '1;
      neg_prev_q <= '1;
      for (int k = 0; k < N_GRP; k++) begin
        slot_q[k] <= SUB_FIRST;
      end
    end else begin
      pos_prev_q <= link.data_strobe_pos_n;
      neg_prev_q <= link.data_strobe_neg_n;
      for (int k = 0; k < N_GRP; k++) begin
        if (link.data_valid_n) begin
          slot_q[k] <= SUB_FIRST;
        end else if (fall[k]) begin
          slot_q[k] <= slot_q[k] + SUB_STEP;
        end
      end
    end
  end

  always_ff @(posedge link.clk_link) begin
    for (int k = 0; k < N_GRP; k++) begin
      if (!link.data_valid_n && fall[k]) begin
        cap_q[slot_q[k]][k*GRP_W +: GRP_W] <=
          word[k*GRP_W +: GRP_W];
      end
    end
  end

  // hold stays still a whole common clock, long enough for mclk to copy
  always_ff @(posedge link.clk_link) begin
    if (done) begin
      hold_q <= {word, cap_q[2], cap_q[1], cap_q[0]};
    end
  end

  always_ff @(posedge link.clk_link or negedge i_nrst) begin
    if (!i_nrst) begin
      done_tgl_q <= 1'b0;
    end else if (done) begin
      done_tgl_q <= ~done_tgl_q;
    end
  end

  // ----------------------------------------------------------------
  // delivery (mclk)
  // ----------------------------------------------------------------
  logic [2:0] tgl_s_q;
  logic seen_q;

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      tgl_s_q <= '0;
      seen_q <= 1'b0;
      o_line_valid <= 1'b0;
    end else begin
      tgl_s_q <= {tgl_s_q[1:0], done_tgl_q};
      o_line_valid <= 1'b0;
      if (tgl_s_q[1] == tgl_s_q[2] && tgl_s_q[2] != seen_q) begin
        seen_q <= tgl_s_q[2];
        o_line_valid <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_line <= '0;
    end else if (tgl_s_q[1] == tgl_s_q[2] && tgl_s_q[2] != seen_q) begin
      o_line <= hold_q;
    end
  end

endmodule // fsbdp_rx_end

`default_nettype wire

//--- bench/fsbdp_link_assertions.sv
// fsbdp_link_assertions: link checks on the wires between the two ends
// assumes the link interface signals and the reset are wired in by name
`default_nettype none

module fsbdp_link_assertions #(
  parameter fsbdp_pkg::fsbdp_freq_t FREQ_SEL = fsbdp_pkg::FREQ_SEL_RST
) (
  // clock and reset
  input wire logic clk_link,
  input wire logic i_nrst,
  // link wires
  input wire logic drv_oe,
  input wire logic [fsbdp_pkg::DATA_W-1:0] data_n,
  input wire logic [fsbdp_pkg::N_GRP-1:0] group_invert_flag_n,
  input wire logic [fsbdp_pkg::N_GRP-1:0] data_strobe_pos_n,
  input wire logic [fsbdp_pkg::N_GRP-1:0] data_strobe_neg_n,
  input wire logic data_valid_n,
  input wire fsbdp_pkg::fsbdp_freq_t bus_freq_select
);
  import fsbdp_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  logic [1:0] sub_q;

  // sub-phase index, restarts in every idle clock
  always_ff @(posedge clk_link or negedge i_nrst) begin
    if (!i_nrst) begin
      sub_q <= 2'h0;
    end else if (data_valid_n) begin
      sub_q <= 2'h0;
    end else begin
      sub_q <= sub_q + 2'h1;
    end
  end

  // an exact 8 stays plain, so flagged groups need more than half
  function automatic logic groups_ok(input logic [DATA_W-1:0] d,
                                     input logic [N_GRP-1:0] f);
    int unsigned ones;
    groups_ok = 1'b1;
    for (int k = 0; k < N_GRP; k++) begin
      ones = $countones(d[GRP_W*k +: GRP_W]);
      if (ones < GRP_W / 2 || (!f[k] && ones == GRP_W / 2)) begin
        groups_ok = 1'b0;
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_link); endclocking
  default disable iff (!i_nrst);

  sequence burst_s;
    !data_valid_n [*4];
  endsequence

  sequence idle_s;
    data_n == '1 && group_invert_flag_n == '1 &&
      data_strobe_pos_n == '1 && data_strobe_neg_n == '1;
  endsequence

  valid_with_oe_a: assert property (data_valid_n == !drv_oe)
    else $error("valid indicator and drive enable disagree");
  four_beats_a: assert property ($fell(data_valid_n) |-> burst_s)
    else $error("burst shorter than four sub-phases");
  whole_clocks_a: assert property ($rose(data_valid_n) |-> sub_q == 2'h0)
    else $error("burst ended inside a common clock");
  strobe_phase_a: assert property (!data_valid_n |->
    data_strobe_pos_n == {N_GRP{sub_q[0]}} &&
    data_strobe_neg_n == {N_GRP{!sub_q[0]}})
    else $error("strobe pair out of phase");
  strobe_toggle_a: assert property (!data_valid_n && $past(!data_valid_n)
    |-> data_strobe_neg_n != $past(data_strobe_neg_n))
    else $error("negative strobe missed a sub-phase");
  idle_release_a: assert property (data_valid_n |-> idle_s)
    else $error("pins not released in idle clock");
  invert_rule_a: assert property (!data_valid_n |->
    groups_ok(data_n, group_invert_flag_n))
    else $error("group inversion flag wrong");
  freq_fixed_a: assert property (bus_freq_select == FREQ_SEL)
    else $error("bus frequency select wrong");

  back_to_back_c: cover property ($fell(data_valid_n) ##4 !data_valid_n);

endmodule // fsbdp_link_assertions

`default_nettype wire

//--- bench/fsb_data_path_inversion_bench.sv
// fsb_data_path_inversion_bench: two ends joined, plus a blocked sender
// assumes the design files and the link checker are compiled first
`default_nettype none

module fsb_data_path_inversion_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import fsbdp_pkg::*;

  // ----------------------------------------------------------------
  // clocks, ends and checker
  // ----------------------------------------------------------------
  logic i_mclk = 1'b0;
  logic clk_link = 1'b0;
  logic i_nrst = 1'b0;
  logic word_valid = 1'b0;
  fsbdp_word_t word = '0;
  logic word_ready;
  logic mismatch;
  logic skew_mismatch;
  logic line_valid;
  fsbdp_line_t line;
  logic skew_sent = 1'b0;
  logic full_seen = 1'b0;
  int bad_count = 0;
  int checks = 0;
  fsbdp_line_t expect_q[$];
  fsbdp_grp_t pat[6] = '{16'h0000, 16'hFFFF, 16'h00FF, 16'h01FF,
                          16'hFF7F, 16'h0001};

  always #4 i_mclk = ~i_mclk;
  // offset start keeps the link clock edges clear of the mclk edges
  initial begin
    #3.1;
    forever #16 clk_link = ~clk_link;
  end

  fsbdp_link_if link (.clk_link(clk_link));
  fsbdp_link_if skew_link (.clk_link(clk_link));
  assign skew_link.bus_freq_select = 2'h2;

  fsbdp_tx_end fsbdp_tx_end_i (.i_mclk(i_mclk), .i_nrst(i_nrst),
    .i_word_valid(word_valid), .i_word(word), .o_word_ready(word_ready),
    .o_freq_mismatch(mismatch), .link(link.tx));
  fsbdp_rx_end fsbdp_rx_end_i (.i_mclk(i_mclk), .i_nrst(i_nrst),
    .link(link.rx), .o_line(line), .o_line_valid(line_valid));
  // sender set to another frequency must never use its bus
  fsbdp_tx_end #(.FREQ_SEL(2'h1)) fsbdp_tx_end_skew_i (.i_mclk(i_mclk),
    .i_nrst(i_nrst), .i_word_valid(word_valid), .i_word(word),
    .o_word_ready(), .o_freq_mismatch(skew_mismatch),
    .link(skew_link.tx));
  fsbdp_link_assertions #(.FREQ_SEL(FREQ_SEL_RST)) fsbdp_link_assertions_i (
    .clk_link(clk_link), .i_nrst(i_nrst), .drv_oe(link.drv_oe),
    .data_n(link.data_n), .group_invert_flag_n(link.group_invert_flag_n),
    .data_strobe_pos_n(link.data_strobe_pos_n),
    .data_strobe_neg_n(link.data_strobe_neg_n),
    .data_valid_n(link.data_valid_n), .bus_freq_select(link.bus_freq_select));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [255:0] seen,
                       input logic [255:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    if (bad_count == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic send_word(input fsbdp_word_t w);
    int n;
    n = 0;
    word_valid <= 1'b1;
    word <= w;
    @(posedge i_mclk);
    while (word_ready !== 1'b1 && n < 2000) begin
      full_seen = 1'b1;
      n++;
      @(posedge i_mclk);
    end
    if (n == 2000) begin
      bad_count++;
    end
  endtask

  // a gap splits the line so the link sees idle clocks meanwhile
  task automatic send_line(input fsbdp_word_t w[4], input int gap);
    expect_q.push_back({w[3], w[2], w[1], w[0]});
    for (int j = 0; j < 4; j++) begin
      if (j == 2 && gap > 0) begin
        word_valid <= 1'b0;
        repeat (gap) @(posedge i_mclk);
      end
      send_word(w[j]);
    end
  endtask

  // ----------------------------------------------------------------
  // watchers and main sequence
  // ----------------------------------------------------------------
  always @(posedge clk_link) begin
    if (skew_link.data_valid_n === 1'b0) begin
      skew_sent <= 1'b1;
    end
  end

  always @(posedge i_mclk) begin
    if (i_nrst && line_valid === 1'b1) begin
      if (expect_q.size() == 0) begin
        check("extra line", 1'b1, 1'b0);
      end else begin
        check("line", line, expect_q.pop_front());
      end
    end
  end

  initial begin
    #100000;
    bad_count++;
    end_of_test();
  end

  initial begin
    fsbdp_word_t w[4];
    int gap;
    void'($urandom(32'hE73B));
    repeat (15) @(posedge i_mclk);
    check("ready in reset", word_ready, 1'b0);
    @(posedge i_mclk);
    i_nrst <= 1'b1;
    repeat (20) @(posedge i_mclk);
    // boundary groups rotated across lanes and sub-phases
    for (int i = 0; i < 6; i++) begin
      for (int j = 0; j < 4; j++) begin
        w[j] = {pat[(i+j+3)%6], pat[(i+j+2)%6], pat[(i+j+1)%6],
                pat[(i+j)%6]};
      end
      send_line(w, 0);
    end
    // back to back first to fill the buffer, then split lines
    for (int i = 0; i < 16; i++) begin
      for (int j = 0; j < 4; j++) begin
        w[j] = {$urandom, $urandom};
      end
      gap = (i < 10) ? 0 : $urandom_range(60, 1);
      send_line(w, gap);
    end
    word_valid <= 1'b0;
    for (int n = 0; n < 3000 && expect_q.size() > 0; n++) begin
      @(posedge i_mclk);
    end
    repeat (20) @(posedge i_mclk);
    check("lines left", expect_q.size(), 0);
    check("refusal seen", full_seen, 1'b1);
    check("select fault", mismatch, 1'b0);
    check("skew fault", skew_mismatch, 1'b1);
    check("skew bus used", skew_sent, 1'b0);
    end_of_test();
  end

endmodule // fsb_data_path_inversion_bench

`default_nettype wire
